// >>> core/pisosr_params.svh
`ifndef PISOSR_PARAMS_SVH
`define PISOSR_PARAMS_SVH

`define PISOSR_WIDTH       8
`define PISOSR_FIFO_DEPTH  16
`define PISOSR_LAST_STAGE  7
`define PISOSR_ZERO8       8'h00

`endif

// >>> core/pisosr_pkg.sv
`default_nettype none
package pisosr_pkg;
  typedef enum logic [1:0] {
    PISOSR_SHIFT,
    PISOSR_LOAD,
    PISOSR_CLEAR
  } pisosr_mode_t;
endpackage
`default_nettype wire

// >>> core/pisosr_fifo.sv
// the word fifo now sits in pisosr_top.sv beside its only user

// >>> core/pisosr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pisosr_params.svh"

// small register fifo for captured words
// count has one spare bit so that full and empty differ
module pisosr_fifo #(
  parameter int WIDTH = `PISOSR_WIDTH,
  parameter int DEPTH = `PISOSR_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } pisosr_fifo_state_t;

  pisosr_fifo_state_t s_q;
  pisosr_fifo_state_t s_d;
  logic               push;
  logic               pop;

  // a full fifo refuses a push, it never overwrites the oldest word
  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rd];

  always_comb
  begin
    s_d  = s_q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;

    if (push)
    begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
    end

    if (pop)
      s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;

    // push and pop together leave the count alone
    if (push && !pop)
      s_d.cnt = s_q.cnt + 1'b1;
    else if (pop && !push)
      s_d.cnt = s_q.cnt - 1'b1;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

// Operation
// - each storage clock rise captures all eight parallel inputs regardless of other controls.
// - an eight-bit storage register feeds an eight-stage shift register with one serial output.
// - the storage register acts only on the rising edge of its own clock; the shift register also follows load and clear levels.
// - load low with clear high copies storage into the shift register with no shift clock edge.
// - a storage clock rise during load passes the fresh parallel data into the shift register.
// - clear low with load high zeroes every shift stage at once, regardless of shift clock.
// - with load and clear high, each shift clock rise moves stage n-1 into n and serial in into 0.
// - load and clear override shift clock edges, so no shift happens while either is active.
module pisosr_top
  import pisosr_pkg::*;
#(
  parameter int WIDTH = `PISOSR_WIDTH,
  parameter int DEPTH = `PISOSR_FIFO_DEPTH
) (
  // system clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // controller pins, sampled on clock
  input  wire logic             store_clk,
  input  wire logic             shift_clk,
  input  wire logic             load_from_store_n,
  input  wire logic             shift_clear_n,
  input  wire logic             serial_in,
  input  wire logic [WIDTH-1:0] par_in,
  // serial output
  output logic                  serial_out,
  // captured words, buffered
  output logic                  word_valid,
  input  wire logic             word_ready,
  output logic      [WIDTH-1:0] word_data,
  output logic                  word_dropped
);
  typedef struct packed {
    logic             store_clk_prev;
    logic             shift_clk_prev;
    logic [WIDTH-1:0] store;
    logic [WIDTH-1:0] stages;
    logic             ser;
    logic             dropped;
    logic             wvalid;
    logic [WIDTH-1:0] wdata;
    pisosr_mode_t     mode;
  } pisosr_state_t;

  pisosr_state_t    s_q;
  pisosr_state_t    s_d;
  logic             store_rise;
  logic             shift_rise;
  logic [WIDTH-1:0] store_next;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [WIDTH-1:0] fifo_out_data;
  logic             drain;

  // captured words leave through the fifo; a capture while it is full shows as word_dropped
  pisosr_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (store_rise),
    .in_ready  (fifo_in_ready),
    .in_data   (par_in),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out_data)
  );

  // output stage is a register; refill only when it is empty or taken
  assign drain = !s_q.wvalid || word_ready;

  always_comb
  begin
    s_d            = s_q;
    store_rise     = store_clk && !s_q.store_clk_prev;
    shift_rise     = shift_clk && !s_q.shift_clk_prev;
    store_next     = store_rise ? par_in : s_q.store;
    s_d.store_clk_prev = store_clk;
    s_d.shift_clk_prev = shift_clk;
    s_d.store      = store_next;
    // clear wins when both low; that state is illegal anyway
    if (!shift_clear_n)
      s_d.mode = PISOSR_CLEAR;
    else if (!load_from_store_n)
      s_d.mode = PISOSR_LOAD;
    else
      s_d.mode = PISOSR_SHIFT;

    // load and clear are levels, so they act on every clock, not on edges
    case (s_d.mode)
      PISOSR_CLEAR:
      begin
        s_d.stages = WIDTH'(`PISOSR_ZERO8);
      end
      PISOSR_LOAD:
      begin
        s_d.stages = store_next;
      end
      PISOSR_SHIFT:
      begin
        // a rise seen under load or clear is lost, not held over
        if (shift_rise)
          s_d.stages = {s_q.stages[WIDTH-2:0], serial_in};
      end
      default:
      begin
        s_d.stages = s_q.stages;
      end
    endcase

    s_d.ser     = s_d.stages[`PISOSR_LAST_STAGE];
    // a capture into a full fifo still updates storage, only the copy is lost
    s_d.dropped = store_rise && !fifo_in_ready;
    if (drain)
    begin
      s_d.wvalid = fifo_out_valid;
      s_d.wdata  = fifo_out_valid ? fifo_out_data : s_q.wdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // outputs are the registers themselves, no logic behind the flops
  assign serial_out   = s_q.ser;
  assign word_valid   = s_q.wvalid;
  assign word_data    = s_q.wdata;
  assign word_dropped = s_q.dropped;
endmodule
`default_nettype wire

// >>> test/pisosr_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pisosr_chk #(parameter int WIDTH = 8)
(
  // watched ports
  input wire logic             clock,
  input wire logic             arst_n,
  input wire logic             store_clk,
  input wire logic             shift_clk,
  input wire logic             load_from_store_n,
  input wire logic             shift_clear_n,
  input wire logic [WIDTH-1:0] par_in,
  input wire logic             serial_out,
  input wire logic             word_valid,
  input wire logic             word_ready,
  input wire logic [WIDTH-1:0] word_data,
  input wire logic             word_dropped
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_ld;
    !load_from_store_n && shift_clear_n && !(store_clk && !$past(store_clk));
  endsequence
  property p_clr; !shift_clear_n && load_from_store_n |=> !serial_out;
  endproperty
  a_clr: assert property (p_clr) else $error("clear missed");
  property p_thru; store_clk && !$past(store_clk)
    && !load_from_store_n && shift_clear_n
    |=> serial_out == $past(par_in[WIDTH-1]); endproperty
  a_thru: assert property (p_thru) else $error("no pass through");
  property p_hold; load_from_store_n && shift_clear_n
    && !(shift_clk && !$past(shift_clk)) |=> $stable(serial_out); endproperty
  a_hold: assert property (p_hold) else $error("moved unclocked");
  property p_keep; s_ld ##1 s_ld |=> $stable(serial_out); endproperty
  a_keep: assert property (p_keep) else $error("load unstable");
  property p_vhold; word_valid && !word_ready |=>
    word_valid && $stable(word_data); endproperty
  a_vhold: assert property (p_vhold) else $error("word lost");
  property p_pulse; word_dropped |=> !word_dropped; endproperty
  a_pulse: assert property (p_pulse) else $error("drop too long");
  property p_full; word_dropped |-> word_valid; endproperty
  a_full: assert property (p_full) else $error("drop when empty");
  property p_rst; $rose(arst_n) |-> !serial_out && !word_valid; endproperty
  a_rst: assert property (p_rst) else $error("reset not clean");
  c_drop: cover property (word_dropped);
  c_load: cover property (!load_from_store_n && store_clk);
  c_clr: cover property (!shift_clear_n && shift_clk);
endmodule
bind pisosr_top pisosr_chk #(.WIDTH(WIDTH)) u_chk (.clock, .arst_n,
  .store_clk, .shift_clk, .load_from_store_n, .shift_clear_n, .par_in,
  .serial_out, .word_valid, .word_ready, .word_data, .word_dropped);
`default_nettype wire

// >>> test/pisosr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pisosr_ctrl
(
  // pins toward the block
  input  wire logic       clock,
  output logic            store_clk,
  output logic            shift_clk,
  output logic            load_from_store_n,
  output logic            shift_clear_n,
  output logic            serial_in,
  output logic      [7:0] par_in
);
  initial {store_clk, shift_clk, load_from_store_n, shift_clear_n,
    serial_in, par_in} = 13'h0600;
  // clocks high one cycle, then low one cycle
  task edges(input logic st, sh, ld, cl, si, input logic [7:0] d);
    @(negedge clock);
    // never both low together
    {store_clk, shift_clk, load_from_store_n, shift_clear_n} =
      {st, sh, ld, cl | !ld};
    {serial_in, par_in} = {si, d};
    @(negedge clock);
    {store_clk, shift_clk} = 2'h0;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_piso_shift_register_with_input_store.sv
`timescale 1ns/1ps
`default_nettype none
module tb_piso_shift_register_with_input_store;
  logic       clock = 0, arst_n = 0, word_ready = 1;
  logic       store_clk, shift_clk, load_from_store_n, shift_clear_n;
  logic       serial_in, serial_out, word_valid, word_dropped;
  logic [7:0] par_in, word_data;
  int         err_total, checks_done, drops, n;
  always #12.5 clock = ~clock;
  always @(posedge clock) drops += (word_dropped === 1'b1);
  pisosr_ctrl u_ctrl (.clock, .store_clk, .shift_clk, .load_from_store_n,
    .shift_clear_n, .serial_in, .par_in);
  pisosr_top DUT (.clock, .arst_n, .store_clk, .shift_clk,
    .load_from_store_n, .shift_clear_n, .serial_in, .par_in, .serial_out,
    .word_valid, .word_ready, .word_data, .word_dropped);
  task chk(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task t_shift;
    u_ctrl.edges(1, 0, 0, 1, 0, 8'ha5);
    chk(serial_out, 8'h01);
    for (int k = 1; k < 16; k++)
    begin
      u_ctrl.edges(0, 1, 1, 1, k[1], 8'h3c);
      chk(serial_out, k < 8 ? (8'ha5 >> (7 - k)) & 8'h01 : 8'((k - 7) >> 1 & 1));
    end
  endtask
  task t_clear;
    u_ctrl.edges(1, 1, 1, 0, 1, 8'h81);
    chk(serial_out, 8'h00);
    u_ctrl.edges(0, 0, 0, 1, 0, 8'h00);
    chk(serial_out, 8'h01);
    u_ctrl.edges(0, 1, 0, 1, 0, 8'h00);
    chk(serial_out, 8'h01);
  endtask
  task t_fifo;
    @(negedge clock) word_ready = 0;
    for (int k = 0; k < 18; k++) u_ctrl.edges(1, 0, 1, 1, 0, 8'(k));
    @(negedge clock);
    chk(8'(drops), 8'h01);
    repeat (40)
    begin
      @(negedge clock);
      if (word_valid === 1'b1)
      begin
        chk(word_data, 8'(n));
        n++;
      end
      word_ready = 1;
    end
    chk(8'(n), 8'h11);
  endtask
  initial
  begin
    repeat (5) @(negedge clock);
    arst_n = 1;
    t_shift();
    t_clear();
    repeat (8) @(negedge clock);
    t_fifo();
    end_of_test();
  end
  initial
  begin
    #20us;
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
